// >>> sdrmr_regs.sv
/*
 * Mode-register bank of one SDRAM channel: refresh masks, DQS oscillator
 * count, upper-byte calibration invert, reserved slot and termination.
 * Assumes commands arrive synchronous to the link clock ck, the set-point
 * select bits come from the frequency set-point logic on ck, and the core
 * refresh sequencer runs on clk. One instance serves one channel.
 */
// Overview of operation
// - bank mask bit n set stops refresh of bank n in self refresh only; default zero.
// - bank mask kept per channel; each channel instance owns its own.
// - segment mask bit n set stops refresh of segment n in self refresh only; default zero.
// - segment n is rows whose row bits 15:13 equal n.
// - segment mask kept per channel; each instance owns its own.
// - oscillator low register returns count bits 7:0.
// - oscillator high register returns count bits 15:8.
// - oscillator start command clears both count registers.
// - invert bit n inverts pattern on upper DQ n; default 55h.
// - upper mask/inversion pin always carries the true pattern.
// - no data bus inversion during calibration readout.
// - termination code: 000 off, 001-110 resistor divided, 111 reserved.
// - bit 3 zero enables clock termination, pad ignored.
// - bit 4 zero enables chip-select termination, pad ignored.
// - bit 5 one disables command/address termination, pad ignored.
// - termination writes and reads use copy chosen by write set point.
// - device runs on copy chosen by operating set point.
// - address 15h is reserved, no function.
// - bank mask sits at address 10h, written by mode write.
`timescale 1ns/10ps
`default_nettype none
// constants pulled in here as well, so the file stands alone when each
// file is its own compilation unit; the guard stops a double definition
`include "sdrmr_defs.svh"

module sdrmr_regs
   import sdrmr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ck,
   input  wire sdrmr_cmd_s  mr_cmd,
   input  wire logic        mpc_valid,
   input  wire logic [6:0]  mpc_op,
   input  wire logic        write_setpoint_select,
   input  wire logic        operating_setpoint_select,
   input  wire logic        calib_read_active,
   input  wire logic [7:0]  calib_pattern,
   input  wire logic        dbi_read_enable,
   input  wire logic        self_refresh_active,
   input  wire logic        rf_req,
   input  wire logic [2:0]  rf_bank,
   input  wire logic [15:0] rf_row,
   output logic [7:0]       mrr_data,
   output logic             mrr_valid,
   output sdrmr_term_s      term_active,
   output logic [7:0]       dq_upper_out,
   output logic             dq_upper_oe,
   output logic             upper_mask_inversion_out,
   output logic             upper_mask_inversion_oe,
   output logic             rf_skip,
   output logic             rf_done
);

   // link-domain reset: asserted at once, released after two ck edges
   logic       ck_rst_meta_reg;
   logic       ck_rst_n_reg;

   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         ck_rst_meta_reg <= 1'b0;
         ck_rst_n_reg    <= 1'b0;
      end else begin
         ck_rst_meta_reg <= 1'b1;
         ck_rst_n_reg    <= ck_rst_meta_reg;
      end
   end

   // register storage, ck domain; masks are private to this channel
   logic [7:0]  bank_refresh_mask_reg;
   logic [7:0]  segment_refresh_mask_reg;
   logic [7:0]  upper_byte_calib_invert_reg;
   logic [7:0]  termination_control_reg [2];
   logic [15:0] osc_count_reg;
   sdrmr_osc_e  osc_state_reg;
   logic        mask_tgl_reg;

   wire logic wr_bank = mr_cmd.wr && (mr_cmd.ma == `SDRMR_MA_BANK_MASK);
   wire logic wr_seg  = mr_cmd.wr && (mr_cmd.ma == `SDRMR_MA_SEG_MASK);
   wire logic wr_inv  = mr_cmd.wr && (mr_cmd.ma == `SDRMR_MA_UB_INVERT);
   wire logic wr_term = mr_cmd.wr && (mr_cmd.ma == `SDRMR_MA_TERM_CTRL);
   wire logic osc_start = mpc_valid && (mpc_op == `SDRMR_MPC_OSC_START);
   wire logic osc_stop  = mpc_valid && (mpc_op == `SDRMR_MPC_OSC_STOP);

   // refresh masks, write-only; a write also flags the core domain
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         bank_refresh_mask_reg    <= `SDRMR_RST_BANK_MASK;
         segment_refresh_mask_reg <= `SDRMR_RST_SEG_MASK;
         mask_tgl_reg             <= 1'b0;
      end else begin
         if (wr_bank) begin
            bank_refresh_mask_reg <= mr_cmd.op;
         end
         if (wr_seg) begin
            segment_refresh_mask_reg <= mr_cmd.op;
         end
         if (wr_bank || wr_seg) begin
            mask_tgl_reg <= ~mask_tgl_reg;
         end
      end
   end

   // upper-byte calibration invert mask, write-only
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         upper_byte_calib_invert_reg <= `SDRMR_RST_UB_INVERT;
      end else if (wr_inv) begin
         upper_byte_calib_invert_reg <= mr_cmd.op;
      end
   end

   // two termination copies; only the write set point's copy is written
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         termination_control_reg[0] <= `SDRMR_RST_TERM_CTRL;
         termination_control_reg[1] <= `SDRMR_RST_TERM_CTRL;
      end else if (wr_term) begin
         termination_control_reg[write_setpoint_select] <= mr_cmd.op;
      end
   end

   // dqs oscillator: start clears the count, counts ck until stopped
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         osc_state_reg <= SDRMR_OSC_IDLE;
         osc_count_reg <= `SDRMR_RST_OSC_COUNT;
      end else begin
         case (osc_state_reg)
            SDRMR_OSC_IDLE: begin
               if (osc_start) begin
                  osc_count_reg <= `SDRMR_RST_OSC_COUNT;
                  osc_state_reg <= SDRMR_OSC_RUN;
               end
            end
            SDRMR_OSC_RUN: begin
               if (osc_start) begin
                  osc_count_reg <= `SDRMR_RST_OSC_COUNT;
               end else if (osc_stop) begin
                  osc_state_reg <= SDRMR_OSC_IDLE;
               end else if (osc_count_reg != 16'hFFFF) begin
                  // saturate rather than wrap so a long run stays monotonic
                  osc_count_reg <= osc_count_reg + 16'h0001;
               end
            end
            default: begin
               osc_state_reg <= SDRMR_OSC_IDLE;
            end
         endcase
      end
   end

   // mode-register read answers one ck later; unmapped reads give no valid
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         mrr_data  <= 8'h00;
         mrr_valid <= 1'b0;
      end else begin
         mrr_valid <= 1'b0;
         mrr_data  <= 8'h00;
         if (mr_cmd.rd) begin
            case (mr_cmd.ma)
               `SDRMR_MA_OSC_LOW: begin
                  mrr_data  <= osc_count_reg[7:0];
                  mrr_valid <= 1'b1;
               end
               `SDRMR_MA_OSC_HIGH: begin
                  mrr_data  <= osc_count_reg[15:8];
                  mrr_valid <= 1'b1;
               end
               `SDRMR_MA_TERM_CTRL: begin
                  mrr_data  <= termination_control_reg[write_setpoint_select];
                  mrr_valid <= 1'b1;
               end
               `SDRMR_MA_BANK_MASK, `SDRMR_MA_SEG_MASK,
               `SDRMR_MA_UB_INVERT, `SDRMR_MA_RESERVED_A: begin
                  // write-only and reserved slots answer zero
                  mrr_valid <= 1'b1;
               end
               default: begin
                  mrr_valid <= 1'b0;
               end
            endcase
         end
      end
   end

   // active termination from the operating set point; the pad plays no part
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         term_active <= '{ctrl_code: 3'h0, ck_en: 1'b1, cs_en: 1'b1,
                          ca_dis: 1'b0};
      end else begin
         // reserved code is treated as disabled
         if (termination_control_reg[operating_setpoint_select][2:0] == `SDRMR_TERM_CODE_RSVD)
         begin
            term_active.ctrl_code <= 3'h0;
         end else begin
            term_active.ctrl_code <=
               termination_control_reg[operating_setpoint_select][2:0];
         end
         term_active.ck_en <=
            ~termination_control_reg[operating_setpoint_select][`SDRMR_TERM_CK_BIT];
         term_active.cs_en <=
            ~termination_control_reg[operating_setpoint_select][`SDRMR_TERM_CS_BIT];
         term_active.ca_dis <=
            termination_control_reg[operating_setpoint_select][`SDRMR_TERM_CA_BIT];
      end
   end

   // calibration readout on the upper byte; inversion by mask only,
   // bus inversion deliberately not consulted
   always_ff @(posedge ck or negedge ck_rst_n_reg) begin
      if (!ck_rst_n_reg) begin
         dq_upper_out             <= 8'h00;
         dq_upper_oe              <= 1'b0;
         upper_mask_inversion_out <= 1'b0;
         upper_mask_inversion_oe  <= 1'b0;
      end else begin
         dq_upper_oe             <= calib_read_active;
         upper_mask_inversion_oe <= calib_read_active;
         if (calib_read_active) begin
            dq_upper_out <= calib_pattern ^
                            upper_byte_calib_invert_reg;
            upper_mask_inversion_out <= calib_pattern[0];
         end else begin
            dq_upper_out             <= 8'h00;
            upper_mask_inversion_out <= 1'b0;
         end
      end
   end

   // mask crossing into clk: toggle through two flops, data taken on the
   // edge; safe because mode writes are spaced far beyond the sync delay
   logic       tgl_meta_reg;
   logic       tgl_sync_reg;
   logic       tgl_seen_reg;
   logic [7:0] core_bank_mask_reg;
   logic [7:0] core_seg_mask_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_meta_reg <= 1'b0;
         tgl_sync_reg <= 1'b0;
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_meta_reg <= mask_tgl_reg;
         tgl_sync_reg <= tgl_meta_reg;
         tgl_seen_reg <= tgl_sync_reg;
      end
   end

   // core copies of the masks, updated once the toggle has settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_bank_mask_reg <= `SDRMR_RST_BANK_MASK;
         core_seg_mask_reg  <= `SDRMR_RST_SEG_MASK;
      end else if (tgl_sync_reg != tgl_seen_reg) begin
         core_bank_mask_reg <= bank_refresh_mask_reg;
         core_seg_mask_reg  <= segment_refresh_mask_reg;
      end
   end

   // per-row refresh decision; masks matter only in self refresh
   wire logic [2:0] rf_segment = rf_row[`SDRMR_SEG_ROW_MSB:`SDRMR_SEG_ROW_LSB];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_skip <= 1'b0;
         rf_done <= 1'b0;
      end else begin
         rf_done <= rf_req;
         if (rf_req) begin
            rf_skip <= self_refresh_active &&
                       (core_bank_mask_reg[rf_bank] ||
                        core_seg_mask_reg[rf_segment]);
         end
      end
   end

   // checks, ck domain
   sequence s_osc_start;
      mpc_valid && (mpc_op == `SDRMR_MPC_OSC_START);
   endsequence

   sequence s_read_low;
      mr_cmd.rd && (mr_cmd.ma == `SDRMR_MA_OSC_LOW);
   endsequence

   chk_osc_start_clear: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      s_osc_start |=> (osc_count_reg == 16'h0000))
      else $error("oscillator count not cleared by start");

   chk_osc_low_read: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      s_read_low |=> mrr_valid && (mrr_data == $past(osc_count_reg[7:0])))
      else $error("low count read returned wrong byte");

   chk_osc_high_read: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      mr_cmd.rd && (mr_cmd.ma == `SDRMR_MA_OSC_HIGH) |=>
         mrr_valid && (mrr_data == $past(osc_count_reg[15:8])))
      else $error("high count read returned wrong byte");

   chk_bank_mask_write: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      mr_cmd.wr && (mr_cmd.ma == 6'h10) |=>
         bank_refresh_mask_reg == $past(mr_cmd.op))
      else $error("bank mask write not stored");

   chk_calib_invert_out: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      calib_read_active |=> dq_upper_oe &&
         (dq_upper_out == ($past(calib_pattern) ^
                           $past(upper_byte_calib_invert_reg))))
      else $error("upper byte calibration data wrong");

   chk_dmi_true_data: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      calib_read_active && dbi_read_enable |=>
         upper_mask_inversion_out == $past(calib_pattern[0]))
      else $error("mask pin carried altered pattern");

   chk_term_write_copy: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      mr_cmd.wr && (mr_cmd.ma == `SDRMR_MA_TERM_CTRL) |=>
         termination_control_reg[$past(write_setpoint_select)] == $past(mr_cmd.op) &&
         termination_control_reg[!$past(write_setpoint_select)] ==
            $past(termination_control_reg[!write_setpoint_select]))
      else $error("termination write hit the wrong copy");

   chk_term_ck_follow: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      $stable(operating_setpoint_select) && $stable(termination_control_reg[operating_setpoint_select]) |=>
         term_active.ck_en == ~$past(termination_control_reg[operating_setpoint_select][3]))
      else $error("clock termination does not follow active copy");

   chk_term_ca_follow: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      1'b1 |=> term_active.ca_dis ==
         $past(termination_control_reg[operating_setpoint_select][`SDRMR_TERM_CA_BIT]))
      else $error("command/address termination does not follow copy");

   chk_reserved_read: assert property (
      @(posedge ck) disable iff (!ck_rst_n_reg)
      mr_cmd.rd && (mr_cmd.ma == `SDRMR_MA_RESERVED_A) |=>
         mrr_valid && (mrr_data == 8'h00))
      else $error("reserved register read non-zero");

   // checks, clk domain
   chk_skip_needs_sr: assert property (
      @(posedge clk) disable iff (!rst_n)
      rf_req && !self_refresh_active |=> rf_done && !rf_skip)
      else $error("row skipped outside self refresh");

   chk_skip_masks: assert property (
      @(posedge clk) disable iff (!rst_n)
      rf_req && self_refresh_active |=> rf_skip ==
         ($past(core_bank_mask_reg[rf_bank]) ||
          $past(core_seg_mask_reg[rf_row[15:13]])))
      else $error("skip decision does not match masks");

endmodule // sdrmr_regs

`default_nettype wire

// >>> sdrmr_defs.svh
/*
 * Constants of the refresh-mask, oscillator-count, calibration-invert and
 * termination mode-register bank: addresses, reset values, opcodes, fields.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef SDRMR_DEFS_SVH
`define SDRMR_DEFS_SVH

// mode-register addresses (6-bit)
`define SDRMR_MA_BANK_MASK     6'h10
`define SDRMR_MA_SEG_MASK      6'h11
`define SDRMR_MA_OSC_LOW       6'h12
`define SDRMR_MA_OSC_HIGH      6'h13
`define SDRMR_MA_UB_INVERT     6'h14
`define SDRMR_MA_RESERVED_A    6'h15
`define SDRMR_MA_TERM_CTRL     6'h16

// reset values
`define SDRMR_RST_BANK_MASK    8'h00
`define SDRMR_RST_SEG_MASK     8'h00
`define SDRMR_RST_UB_INVERT    8'h55
`define SDRMR_RST_TERM_CTRL    8'h00
`define SDRMR_RST_OSC_COUNT    16'h0000

// multipurpose command opcodes for the DQS oscillator
`define SDRMR_MPC_OSC_START    7'h4B
`define SDRMR_MPC_OSC_STOP     7'h4D

// termination control fields
`define SDRMR_TERM_CODE_LSB    0
`define SDRMR_TERM_CODE_MSB    2
`define SDRMR_TERM_CK_BIT      3
`define SDRMR_TERM_CS_BIT      4
`define SDRMR_TERM_CA_BIT      5
`define SDRMR_TERM_CODE_RSVD   3'h7

// segment field position in the row address for an 8Gb channel
`define SDRMR_SEG_ROW_MSB      15
`define SDRMR_SEG_ROW_LSB      13

`endif

// >>> sdrmr_pkg.sv
/*
 * Types of the mode-register bank: command carrier, termination bundle
 * and oscillator state. Assumes sdrmr_defs.svh is on the include path.
 */
package sdrmr_pkg;
   `include "sdrmr_defs.svh"

   // one mode-register command from the controller, sampled on ck
   typedef struct packed {
      logic       wr;          // mode_register_write
      logic       rd;          // mode_register_read
      logic [5:0] ma;          // register address
      logic [7:0] op;          // write operand
   } sdrmr_cmd_s;

   // active termination settings applied by the device
   typedef struct packed {
      logic [2:0] ctrl_code;   // controller_termination_code
      logic       ck_en;       // clock_term_enable
      logic       cs_en;       // chip_select_term_enable
      logic       ca_dis;      // cmd_addr_term_disable
   } sdrmr_term_s;

   // oscillator state, gray along idle -> run
   typedef enum logic [0:0] {
      SDRMR_OSC_IDLE = 1'b0,
      SDRMR_OSC_RUN  = 1'b1
   } sdrmr_osc_e;
endpackage : sdrmr_pkg

// >>> sdrmr_ctrl_model.sv
/*
 * Memory-controller model: issues mode-register writes and reads and the
 * multipurpose oscillator commands on the link clock.
 * Assumes the device samples every command on the rising edge of ck.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sdrmr_defs.svh"

module sdrmr_ctrl_model
   import sdrmr_pkg::*;
#(
   parameter bit ODD_DENSITY = 1'b0
)(
   input  wire logic       ck,
   output var  sdrmr_cmd_s mr_cmd,
   output var  logic       mpc_valid,
   output var  logic [6:0] mpc_op
);
   // bus starts idle with zero payload; after each command the payload is left scrambled
   initial begin
      mr_cmd    = '0;
      mpc_valid = 1'b0;
      mpc_op    = 7'h00;
   end

   // one command held for exactly one ck; the payload then lingers inverted
   task automatic send(input logic w, input logic [5:0] ma,
                       input logic [7:0] op);
      @(posedge ck);
      #1;
      mr_cmd = {w, ~w, ma, op};
      @(posedge ck);
      #1;
      mr_cmd = {2'b00, ~ma, ~op};
   endtask

   // writes are tidied to what a legal controller would ever program
   task automatic mode_register_write(input logic [5:0] ma, input logic [7:0] op);
      logic [7:0] v;
      v = op;
      if (ma == `SDRMR_MA_SEG_MASK && ODD_DENSITY) begin
         v[7:6] = 2'b00;
      end
      if (ma == `SDRMR_MA_TERM_CTRL) begin
         v[2:0] = {v[2], ~v[2] & v[1], 1'b0};
      end
      send(1'b1, ma, v);
   endtask

   // the count is only meaningful as both halves, low half first
   task automatic read_count();
      send(1'b0, `SDRMR_MA_OSC_LOW, 8'h00);
      send(1'b0, `SDRMR_MA_OSC_HIGH, 8'h00);
   endtask

   // multipurpose command pulse, one ck wide
   task automatic multipurpose_command(input logic [6:0] op);
      @(posedge ck);
      #1;
      mpc_valid = 1'b1;
      mpc_op    = op;
      @(posedge ck);
      #1;
      mpc_valid = 1'b0;
      mpc_op    = ~op;
   endtask
endmodule // sdrmr_ctrl_model

`default_nettype wire

// >>> test_sdrmr_regs.sv
/*
 * Self-checking bench of the mode-register bank: registers, termination
 * set points, oscillator count, calibration pins and refresh masking.
 * Assumes the controller model file and the package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sdrmr_defs.svh"

module test_sdrmr_regs
   import sdrmr_pkg::*;
;
   logic        clk, rst_n, ck, write_setpoint_select, operating_setpoint_select, calib_read_active;
   logic        dbi_read_enable, self_refresh_active, rf_req;
   logic        mrr_valid, dq_upper_oe, upper_mask_inversion_out;
   logic        upper_mask_inversion_oe, rf_skip, rf_done, mpc_valid;
   logic [7:0]  calib_pattern, mrr_data, dq_upper_out, bm, sm, inv, op;
   logic [7:0]  copy0, copy1;
   logic [6:0]  mpc_op;
   logic [2:0]  rf_bank;
   logic [15:0] rf_row;
   sdrmr_cmd_s  mr_cmd;
   sdrmr_term_s term_active;
   logic [7:0]  rdq[$];
   logic        rfq[$];
   int          seed, mismatches, comparisons;

   sdrmr_ctrl_model u_sdrmr_ctrl_model (.ck(ck), .mr_cmd(mr_cmd),
      .mpc_valid(mpc_valid), .mpc_op(mpc_op));

   sdrmr_regs u_sdrmr_regs (.clk(clk), .rst_n(rst_n), .ck(ck),
      .mr_cmd(mr_cmd), .mpc_valid(mpc_valid), .mpc_op(mpc_op),
      .write_setpoint_select(write_setpoint_select), .operating_setpoint_select(operating_setpoint_select),
      .calib_read_active(calib_read_active), .calib_pattern(calib_pattern),
      .dbi_read_enable(dbi_read_enable),
      .self_refresh_active(self_refresh_active), .rf_req(rf_req),
      .rf_bank(rf_bank), .rf_row(rf_row), .mrr_data(mrr_data),
      .mrr_valid(mrr_valid), .term_active(term_active),
      .dq_upper_out(dq_upper_out), .dq_upper_oe(dq_upper_oe),
      .upper_mask_inversion_out(upper_mask_inversion_out),
      .upper_mask_inversion_oe(upper_mask_inversion_oe),
      .rf_skip(rf_skip), .rf_done(rf_done));

   // core clock, then the link clock on an unrelated phase
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      ck = 1'b0;
      #3.7;
      forever #16 ck = ~ck;
   end

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // note the answer first so the monitor can never race ahead of it
   task automatic rd(input logic [5:0] ma, input logic [7:0] exp);
      rdq.push_back(exp);
      u_sdrmr_ctrl_model.send(1'b0, ma, 8'h00);
   endtask

   function automatic logic [15:0] texp(input logic [7:0] v);
      return {10'h000, v[2:0], ~v[3], ~v[4], v[5]};
   endfunction

   // one calibration beat with read inversion requested on purpose
   task automatic calib(input logic [7:0] p);
      @(posedge ck);
      #1;
      calib_read_active = 1'b1;
      calib_pattern     = p;
      dbi_read_enable   = 1'b1;
      @(posedge ck);
      #1;
      check("dq_upper", {7'h00, 1'b1, p ^ inv},
            {7'h00, dq_upper_oe, dq_upper_out});
      check("mask_pin", {14'h0000, p[0], 1'b1},
            {14'h0000, upper_mask_inversion_out,
             upper_mask_inversion_oe});
      calib_read_active = 1'b0;
      calib_pattern     = ~p;
      @(posedge ck);
      #1;
      check("pins_off", 16'h0000, {14'h0000, dq_upper_oe,
            upper_mask_inversion_oe});
   endtask

   // read answers: an answer with nothing noted is itself a failure
   always @(posedge ck) begin
      if (mrr_valid === 1'b1) begin
         if (rdq.size() == 0) check("mrr_valid", 16'h0000, 16'h0001);
         else check("mrr_data", {8'h00, rdq.pop_front()}, {8'h00, mrr_data});
      end
   end
   always @(posedge clk) begin
      if (rf_done === 1'b1) begin
         if (rfq.size() == 0) check("rf_done", 16'h0000, 16'h0001);
         else check("rf_skip", {15'h0000, rfq.pop_front()},
                    {15'h0000, rf_skip});
      end
   end

   // watchdog: the whole sequence needs about 13 us
   initial begin
      #60000;
      mismatches++;
      results();
   end

   initial begin
      seed = 32'h9CE3;
      {rst_n, write_setpoint_select, operating_setpoint_select, calib_read_active, dbi_read_enable} = '0;
      {self_refresh_active, rf_req, rf_bank, rf_row} = '0;
      calib_pattern = 8'h00;
      inv = `SDRMR_RST_UB_INVERT;
      {copy0, copy1} = 16'h0000;
      repeat (12) @(posedge clk);
      repeat (2) @(posedge ck);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge ck);
      #1;
      check("term_reset", texp(8'h00),
            16'(term_active));
      rd(`SDRMR_MA_UB_INVERT, 8'h00);
      u_sdrmr_ctrl_model.mode_register_write(`SDRMR_MA_RESERVED_A, 8'hFF);
      rd(`SDRMR_MA_RESERVED_A, 8'h00);
      u_sdrmr_ctrl_model.send(1'b0, 6'h17, 8'h00);
      calib(8'h5A);
      inv = 8'($random(seed));
      u_sdrmr_ctrl_model.mode_register_write(`SDRMR_MA_UB_INVERT, inv);
      for (int i = 0; i < 4; i++) calib(8'($random(seed)));
      // termination copies: write both set points in turn while running on set point 0
      for (int i = 0; i < 6; i++) begin
         op = {2'b00, 3'($random(seed)), 3'(2 * (i % 3))};
         write_setpoint_select = i[0];
         if (i[0]) copy1 = op;
         else copy0 = op;
         u_sdrmr_ctrl_model.mode_register_write(`SDRMR_MA_TERM_CTRL, op);
         rd(`SDRMR_MA_TERM_CTRL, op);
         check("term_op0", texp(copy0), 16'(term_active));
      end
      operating_setpoint_select = 1'b1;
      repeat (3) @(posedge ck);
      #1;
      check("term_op1", texp(copy1), 16'(term_active));
      // oscillator: long run, then a restart that must clear the count
      u_sdrmr_ctrl_model.multipurpose_command(`SDRMR_MPC_OSC_START);
      repeat (298) @(posedge ck);
      u_sdrmr_ctrl_model.multipurpose_command(`SDRMR_MPC_OSC_STOP);
      repeat (5) @(posedge ck);
      rdq.push_back(8'h2B);
      rdq.push_back(8'h01);
      u_sdrmr_ctrl_model.read_count();
      u_sdrmr_ctrl_model.multipurpose_command(`SDRMR_MPC_OSC_START);
      u_sdrmr_ctrl_model.multipurpose_command(`SDRMR_MPC_OSC_STOP);
      rdq.push_back(8'h01);
      rdq.push_back(8'h00);
      u_sdrmr_ctrl_model.read_count();
      // refresh masking, back-to-back requests, last four outside self refresh
      bm = 8'($random(seed));
      sm = 8'($random(seed));
      u_sdrmr_ctrl_model.mode_register_write(`SDRMR_MA_BANK_MASK, bm);
      u_sdrmr_ctrl_model.mode_register_write(`SDRMR_MA_SEG_MASK, sm);
      rd(`SDRMR_MA_BANK_MASK, 8'h00);
      repeat (4) @(posedge ck);
      @(posedge clk);
      #1;
      for (int i = 0; i < 40; i++) begin
         self_refresh_active = (i < 36);
         rf_req  = 1'b1;
         rf_bank = 3'($random(seed));
         rf_row  = 16'($random(seed));
         rfq.push_back(self_refresh_active & (bm[rf_bank] |
                       sm[rf_row[15:13]]));
         @(posedge clk);
         #1;
      end
      rf_req = 1'b0;
      repeat (4) @(posedge ck);
      check("left_over", 16'h0000, 16'(rdq.size() + rfq.size()));
      results();
   end
endmodule // test_sdrmr_regs

`default_nettype wire
